// ==== design/card_write_fifo.sv ====
// Purpose: posted write buffer for one socket
// Assumes: one clock, asynchronous active-low reset
// Notes: storage is not reset, only the pointers and the count
`timescale 1ns/10ps
`include "host_port_params.svh"
module card_write_fifo
  import host_port_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic arst_n_i, // Reset, active low
  input wire logic in_valid_i, // Entry offered
  output logic in_ready_o, // Space free
  input host_port_pkg::card_req_t in_data_i, // Entry
  output logic out_valid_o, // Entry waiting
  input wire logic out_ready_i, // Card side takes
  output host_port_pkg::card_req_t out_data_o, // Oldest
  output logic empty_o // Nothing pending
);
  // ========================================================
  // Storage and pointers
  card_req_t mem_r [`FIFO_DEPTH]; // Entry flops
  logic [`FIFO_AW-1:0] wp_r; // Write index
  logic [`FIFO_AW-1:0] rp_r; // Read index
  logic [`FIFO_CW-1:0] cnt_r; // Entries held
  logic push; // Entry accepted
  logic pop; // Entry removed

  assign in_ready_o = (cnt_r != `FIFO_CW'(`FIFO_DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign empty_o = (cnt_r == '0);
  assign out_data_o = mem_r[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Write entry into storage
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  // Pointer and count upkeep
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + `FIFO_AW'(1);
      if (pop)
        rp_r <= rp_r + `FIFO_AW'(1);
      cnt_r <= cnt_r + `FIFO_CW'(push) - `FIFO_CW'(pop);
    end
  end

  // ========================================================
  // Checks
  fifo_depth_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    cnt_r <= `FIFO_CW'(`FIFO_DEPTH))
    else $error("write buffer holds more than four words");
  fifo_full_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (cnt_r == `FIFO_CW'(`FIFO_DEPTH)) |-> !in_ready_o && wp_r == rp_r)
    else $error("write buffer full yet ready or pointers apart");
endmodule // card_write_fifo

// ==== design/host_port_params.svh ====
// Purpose: constants for the bus-sizing host port
// Assumes: included by the design modules
// Notes: definitions only
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH
// ==========================================================
// System bus addresses
`define IDX_PORT 16'h03E0
`define DAT_PORT 16'h03E1
`define SHARED_A 16'h03F7
`define SHARED_B 16'h0377
`define SOCK_BIT 12
`define WIN_BIT 13
// ==========================================================
// Internal register indexes
`define IX_EXT_PTR 8'h2E
`define IX_EXT_WIN 8'h2F
`define IX_TSET_PFX 5'h06
`define IX_WIN_TSEL 8'h38
`define IX_IO_MASK 8'h39
`define IX_STATUS 8'h3A
// ==========================================================
// Reset and power-up values
`define PTR_RST 8'h00
`define T0_SETUP 8'h01
`define T0_CMD 8'h06
`define T0_REC 8'h00
`define T1_SETUP 8'h01
`define T1_CMD 8'h07
`define T1_REC 8'h00
`define WIN_TSEL_RST 8'h00
`define IO_MASK_RST 4'h0
// ==========================================================
// Data mask modes for shared I/O reads
`define MASK_NONE 2'h0
`define MASK_NO_B7 2'h1
`define MASK_ONLY_B7 2'h2
// ==========================================================
// Sizes and counts
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define FIFO_CW 3
`define EXT_BANK_N 8
`define EXT_AW 3
`define STRAP_WAIT 2'h3
`endif

// ==== design/host_port_pkg.sv ====
// Purpose: types shared by the host port modules
// Assumes: constants come from host_port_params.svh
// Notes: types only
package host_port_pkg;
  // ========================================================
  // Host cycle sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_STALL = 2'b10,
    ST_RDWAIT = 2'b11
  } cyc_state_t;
  // Card access carried to a socket
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
    logic [1:0] be;
    logic is_io;
    logic tsel;
    logic sock;
  } card_req_t;
  // One timing set
  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] cmd;
    logic [7:0] recov;
  } card_timing_t;
  // Byte lane decode of one cycle
  typedef struct packed {
    logic lo;
    logic hi;
    logic ok;
  } lanes_t;
  // Filtered bus pins, active high
  typedef struct packed {
    logic ior;
    logic iow;
    logic memr;
    logic memw;
    logic aen;
    logic sbhe;
    logic pwr;
    logic strap;
  } pins_t;
endpackage

// ==== design/isa_host_port.sv ====
// Purpose: system bus side of a two-socket card adapter
// Assumes: bus pins asynchronous, 40 MHz core clock
// Notes: registers reached through pointer and data ports
`timescale 1ns/10ps
`include "host_port_params.svh"
module isa_host_port
  import host_port_pkg::*;
(
  input wire logic clk_i, // Core clock
  input wire logic arst_n_i, // Reset, active low
  input wire logic system_power_ok_i, // Power good pin
  input wire logic speaker_or_socket_select_pin_i, // Strap
  input wire logic [19:0] sa_i, // System address
  input wire logic sbhe_n_i, // Byte high enable
  input wire logic ior_n_i, // I/O read strobe
  input wire logic iow_n_i, // I/O write strobe
  input wire logic memr_n_i, // Memory read strobe
  input wire logic memw_n_i, // Memory write strobe
  input wire logic aen_i, // DMA address enable
  input wire logic [15:0] sd_i, // Data bus in
  output logic [15:0] sd_o, // Data bus out
  output logic [15:0] sd_oe_n_o, // Drive enable, low
  output logic iochrdy_o, // Ready, low inserts waits
  output logic iocs16_n_o, // I/O word ack
  output logic memcs16_n_o, // Memory word ack
  output host_port_pkg::card_req_t [1:0] card_wr_o, // Posted
  output logic [1:0] card_wr_valid_o, // Posted valid
  input wire logic [1:0] card_wr_ready_i, // Card takes
  output host_port_pkg::card_req_t card_rd_o, // Read req
  output logic card_rd_req_o, // Read pulse
  input wire logic card_rd_valid_i, // Read data ready
  input wire logic [15:0] card_rd_data_i, // Read data
  output host_port_pkg::card_timing_t [1:0] card_timing_o // Sets
);
  import host_port_pkg::*;
  // ========================================================
  // Declarations
  pins_t raw; // Pins, active high
  pins_t s1_r; // First sync stage
  pins_t s2_r; // Second sync stage
  pins_t s3_r; // Third sync stage
  pins_t filt_r; // Agreed pin levels
  logic pwr_prev_r; // Power ok history
  logic wide_r; // Wide bus mode
  logic [1:0] strap_cnt_r; // Strap wait count
  logic strap_done_r; // Strap captured
  logic strap_r; // Socket swap strap
  cyc_state_t state_r; // Cycle sequencer
  cyc_state_t state_nxt; // Its next value
  card_req_t req_r; // Stalled or read request
  logic cur_word_r; // Word cycle in progress
  logic cur_io_r; // I/O cycle in progress
  logic rd_sent_r; // Card read issued
  logic [7:0] ptr_r; // Register pointer
  logic [7:0] ext_ptr_r; // Second level pointer
  logic [7:0] ext_bank_r [`EXT_BANK_N]; // Extension bank
  card_timing_t [1:0] tset_r; // Timing sets
  logic [7:0] win_tsel_r; // Window timing select
  logic [3:0] io_mask_r; // Data mask per socket
  logic cyc_on; // Strobe active
  logic start; // New cycle seen
  logic is_io; // I/O cycle
  logic is_rd; // Read cycle
  lanes_t ln; // Lane decode
  logic reg_hit; // Port address hit
  logic sock; // Target socket
  card_req_t new_req; // Request from pins
  logic wr_en; // Internal write
  logic [7:0] wr_idx; // Write index
  logic [7:0] wr_val; // Write value
  logic [7:0] rd_val; // Pointed register
  logic [1:0] push_v; // Push per socket
  card_req_t push_d; // Pushed entry
  logic [1:0] fifo_rdy_w; // Space per socket
  logic [1:0] fifo_empty; // Drained per socket
  logic [1:0] mmode; // Mask mode of read
  logic shared; // Shared floppy address

  // ========================================================
  // Helpers
  // Lane decode from mode, byte high and SA0
  function automatic lanes_t lane_dec(input logic wide,
                                      input logic hi_en,
                                      input logic a0);
    lanes_t l;
    if (!wide)
      l = '{lo: 1'b1, hi: 1'b0, ok: 1'b1};
    else
      l = '{lo: !a0, hi: hi_en, ok: hi_en || !a0};
    return l;
  endfunction
  // Place a card word on the bus lanes
  function automatic logic [15:0] to_bus(input logic wide,
                                         input logic a0,
                                         input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (!wide)
      v = {8'h00, a0 ? d[15:8] : d[7:0]};
    return v;
  endfunction
  // Drive enables, active low, for given lanes
  function automatic logic [15:0] lane_oe(input lanes_t l);
    return ~{{8{l.hi}}, {8{l.lo}}};
  endfunction

  // ========================================================
  // Pin synchronisers, change taken when stages 2 and 3 agree
  assign raw = '{ior: !ior_n_i, iow: !iow_n_i, memr: !memr_n_i,
                 memw: !memw_n_i, aen: aen_i, sbhe: !sbhe_n_i,
                 pwr: system_power_ok_i,
                 strap: speaker_or_socket_select_pin_i};
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      filt_r <= '0;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= (s2_r == s3_r) ? s3_r : filt_r;
    end
  end

  // ========================================================
  // Bus width detection, sticky until reset
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      wide_r <= 1'b0;
    else if (filt_r.sbhe)
      wide_r <= 1'b1;
  end

  // Strap capture once the filter has settled after reset
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      strap_cnt_r <= '0;
      strap_done_r <= 1'b0;
      strap_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == `STRAP_WAIT)
      begin
        // Take the level the filter agrees on at this same edge
        strap_r <= (s2_r.strap == s3_r.strap) ? s3_r.strap :
                   filt_r.strap;
        strap_done_r <= 1'b1;
      end
    end
  end

  // ========================================================
  // Cycle decode
  assign cyc_on = (filt_r.ior | filt_r.iow | filt_r.memr |
                   filt_r.memw) & !filt_r.aen;
  assign start = (state_r == ST_IDLE) && cyc_on;
  assign is_io = filt_r.ior | filt_r.iow;
  assign is_rd = filt_r.ior | filt_r.memr;
  assign ln = lane_dec(wide_r, filt_r.sbhe, sa_i[0]);
  assign reg_hit = is_io && (sa_i[15:0] == `IDX_PORT ||
                             sa_i[15:0] == `DAT_PORT);
  assign sock = sa_i[`SOCK_BIT] ^ strap_r;
  // Request built from the pins
  always_comb
  begin
    new_req.addr = sa_i;
    new_req.data = wide_r ? sd_i : {sd_i[7:0], sd_i[7:0]};
    new_req.be = {ln.hi || (!wide_r && sa_i[0]),
                  ln.lo && (wide_r || !sa_i[0])};
    new_req.is_io = is_io;
    new_req.tsel = win_tsel_r[{sock, is_io, sa_i[`WIN_BIT]}];
    new_req.sock = sock;
  end

  // Internal register write from the ports
  always_comb
  begin
    wr_en = 1'b0;
    wr_idx = ptr_r;
    wr_val = (ln.hi && !ln.lo) ? sd_i[15:8] : sd_i[7:0];
    if (start && reg_hit && !is_rd && ln.ok)
    begin
      if (sa_i[0])
        wr_en = 1'b1;
      else if (ln.hi)
      begin
        wr_en = 1'b1; // Word: pointer low, data high
        wr_idx = sd_i[7:0];
        wr_val = sd_i[15:8];
      end
    end
  end

  // Read mux of the pointed register
  always_comb
  begin
    rd_val = 8'h00;
    unique case (ptr_r)
      `IX_EXT_PTR: rd_val = ext_ptr_r;
      `IX_EXT_WIN: rd_val = (ext_ptr_r < 8'(`EXT_BANK_N)) ?
                   ext_bank_r[ext_ptr_r[`EXT_AW-1:0]] : 8'h00;
      `IX_WIN_TSEL: rd_val = win_tsel_r;
      `IX_IO_MASK: rd_val = {4'h0, io_mask_r};
      `IX_STATUS: rd_val = {4'h0, fifo_empty, strap_r, wide_r};
      default:
      begin
        if (ptr_r[7:3] == `IX_TSET_PFX)
          unique case (ptr_r[1:0])
            2'h0: rd_val = tset_r[ptr_r[2]].setup;
            2'h1: rd_val = tset_r[ptr_r[2]].cmd;
            2'h2: rd_val = tset_r[ptr_r[2]].recov;
            default: rd_val = 8'h00;
          endcase
      end
    endcase
  end

  // ========================================================
  // Register pointer, reset to a known index
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ptr_r <= `PTR_RST;
    else if (start && reg_hit && !is_rd && !sa_i[0] && ln.ok)
      ptr_r <= sd_i[7:0];
  end

  // Extension bank and its pointer keep contents over reset
  always_ff @(posedge clk_i)
  begin
    if (wr_en && wr_idx == `IX_EXT_PTR)
      ext_ptr_r <= wr_val;
    if (wr_en && wr_idx == `IX_EXT_WIN &&
        ext_ptr_r < 8'(`EXT_BANK_N))
      ext_bank_r[ext_ptr_r[`EXT_AW-1:0]] <= wr_val;
  end

  // Timing sets reloaded on power-ok rise, window controls only on reset
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pwr_prev_r <= 1'b0;
      tset_r[0] <= '{`T0_SETUP, `T0_CMD, `T0_REC};
      tset_r[1] <= '{`T1_SETUP, `T1_CMD, `T1_REC};
      win_tsel_r <= `WIN_TSEL_RST;
      io_mask_r <= `IO_MASK_RST;
    end
    else
    begin
      pwr_prev_r <= filt_r.pwr;
      if (filt_r.pwr && !pwr_prev_r)
      begin
        tset_r[0] <= '{`T0_SETUP, `T0_CMD, `T0_REC};
        tset_r[1] <= '{`T1_SETUP, `T1_CMD, `T1_REC};
      end
      else if (wr_en && wr_idx[7:3] == `IX_TSET_PFX)
      begin
        unique case (wr_idx[1:0])
          2'h0: tset_r[wr_idx[2]].setup <= wr_val;
          2'h1: tset_r[wr_idx[2]].cmd <= wr_val;
          2'h2: tset_r[wr_idx[2]].recov <= wr_val;
          default: ;
        endcase
      end
      if (wr_en && wr_idx == `IX_WIN_TSEL)
        win_tsel_r <= wr_val;
      if (wr_en && wr_idx == `IX_IO_MASK)
        io_mask_r <= wr_val[3:0];
    end
  end
  assign card_timing_o = tset_r;

  // ========================================================
  // Cycle sequencer
  always_comb
  begin
    state_nxt = state_r;
    push_v = 2'b00;
    push_d = new_req;
    unique case (state_r)
      ST_IDLE:
        if (start)
        begin
          state_nxt = ST_HOLD;
          if (!reg_hit && ln.ok && !is_rd)
          begin
            if (fifo_rdy_w[sock])
              push_v[sock] = 1'b1;
            else
              state_nxt = ST_STALL;
          end
          else if (!reg_hit && ln.ok)
            state_nxt = ST_RDWAIT;
        end
      ST_HOLD:
        if (!cyc_on)
          state_nxt = ST_IDLE;
      ST_STALL:
      begin
        push_d = req_r;
        if (fifo_rdy_w[req_r.sock])
        begin
          push_v[req_r.sock] = 1'b1;
          state_nxt = ST_HOLD;
        end
      end
      ST_RDWAIT:
        if (card_rd_valid_i && rd_sent_r)
          state_nxt = ST_HOLD;
    endcase
  end

  // Sequencer state and cycle attributes
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r <= ST_IDLE;
      req_r <= '0;
      cur_word_r <= 1'b0;
      cur_io_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (start)
      begin
        req_r <= new_req;
        cur_word_r <= wide_r && ln.lo && ln.hi;
        cur_io_r <= is_io;
      end
    end
  end

  // Card read request, issued once its buffer has drained
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rd_sent_r <= 1'b0;
      card_rd_req_o <= 1'b0;
    end
    else
    begin
      card_rd_req_o <= (state_r == ST_RDWAIT) && !rd_sent_r &&
                       fifo_empty[req_r.sock];
      if (state_r != ST_RDWAIT)
        rd_sent_r <= 1'b0;
      else if (fifo_empty[req_r.sock])
        rd_sent_r <= 1'b1;
    end
  end
  assign card_rd_o = req_r;

  // ========================================================
  // Read data and lane drive
  assign mmode = io_mask_r[{req_r.sock, 1'b0} +: 2];
  assign shared = req_r.is_io && (req_r.addr[15:0] == `SHARED_A ||
                                  req_r.addr[15:0] == `SHARED_B);
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sd_o <= '0;
      sd_oe_n_o <= '1;
    end
    else if (start && reg_hit && is_rd && ln.ok)
    begin
      sd_oe_n_o <= lane_oe(ln);
      if (ln.lo && ln.hi)
        sd_o <= {rd_val, ptr_r};
      else
        sd_o <= sa_i[0] ? {rd_val, rd_val} : {8'h00, ptr_r};
    end
    else if (state_r == ST_RDWAIT && state_nxt == ST_HOLD)
    begin
      sd_o <= to_bus(wide_r, req_r.addr[0], card_rd_data_i);
      sd_oe_n_o <= lane_oe(lane_dec(wide_r, cur_word_r ||
                   req_r.be[1] && wide_r, req_r.addr[0]));
      if (shared && mmode == `MASK_NO_B7)
        sd_oe_n_o[7] <= 1'b1;
      else if (shared && mmode == `MASK_ONLY_B7)
        sd_oe_n_o <= 16'hFF7F;
    end
    else if (!cyc_on)
      sd_oe_n_o <= '1;
  end

  // Handshake outputs
  assign iochrdy_o = !(state_r == ST_STALL || state_r == ST_RDWAIT);
  assign iocs16_n_o = !(state_r != ST_IDLE && cur_word_r &&
                        cur_io_r);
  assign memcs16_n_o = !(state_r != ST_IDLE && cur_word_r &&
                         !cur_io_r);

  // ========================================================
  // Posted write buffers, one per socket
  for (genvar g = 0; g < 2; g++)
  begin : g_fifo
    card_write_fifo u_fifo (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .in_valid_i(push_v[g]),
      .in_ready_o(fifo_rdy_w[g]),
      .in_data_i(push_d),
      .out_valid_o(card_wr_valid_o[g]),
      .out_ready_i(card_wr_ready_i[g]),
      .out_data_o(card_wr_o[g]),
      .empty_o(fifo_empty[g])
    );
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wide_sticky_a: assert property (wide_r |=> wide_r)
    else $error("wide mode dropped without reset");
  wide_entry_a: assert property (filt_r.sbhe |=> wide_r)
    else $error("byte high seen but still narrow");
  narrow_lanes_a: assert property (!wide_r |-> &sd_oe_n_o[15:8])
    else $error("upper lane driven in narrow mode");
  cs16_wide_a: assert property (
    !iocs16_n_o || !memcs16_n_o |-> wide_r)
    else $error("word ack in narrow mode");
  no_wait_a: assert property (
    start && !reg_hit && !is_rd && ln.ok && fifo_rdy_w[sock]
    |=> iochrdy_o)
    else $error("wait inserted with buffer room");
  stall_full_a: assert property (
    start && !reg_hit && !is_rd && ln.ok && !fifo_rdy_w[sock]
    |=> !iochrdy_o)
    else $error("full buffer did not stall");
  ptr_load_a: assert property (
    start && reg_hit && !is_rd && !sa_i[0] && ln.ok
    |=> ptr_r == $past(sd_i[7:0]))
    else $error("pointer not loaded");
  pwr_load_a: assert property (
    filt_r.pwr && !pwr_prev_r
    |=> tset_r[0].cmd == `T0_CMD && tset_r[1].cmd == `T1_CMD)
    else $error("timing sets not loaded on power ok");
  mask_b7_a: assert property (
    state_r == ST_RDWAIT && state_nxt == ST_HOLD && shared &&
    mmode == `MASK_NO_B7 |=> sd_oe_n_o[7])
    else $error("bit 7 driven while masked");
  only_b7_a: assert property (
    state_r == ST_RDWAIT && state_nxt == ST_HOLD && shared &&
    mmode == `MASK_ONLY_B7 |=> sd_oe_n_o == 16'hFF7F)
    else $error("bits other than 7 driven");
  word_cov_c: cover property (!memcs16_n_o);
  stall_cov_c: cover property (state_r == ST_STALL ##1
    state_r == ST_HOLD);
  ext_cov_c: cover property (wr_en && wr_idx == `IX_EXT_WIN);
endmodule // isa_host_port

// ==== test/isa_master.sv ====
// Purpose: system bus master model driving host port cycles
// Assumes: one 40 MHz clock, strobes active low
// Notes: released data lines show the inverse of the last value
`timescale 1ns/10ps
module isa_master (
  input wire logic clk_i, // Clock
  input wire logic rdy_i, // Bus ready, low inserts waits
  input wire logic [15:0] sd_i, // Device data
  input wire logic [15:0] oe_n_i, // Device drive enables
  input wire logic cs_n_i, // Either word acknowledge
  output logic [19:0] sa_o, // Address
  output logic sbhe_n_o, // Byte high enable
  output logic [3:0] st_n_o, // Strobes: ior, iow, memr, memw
  output logic [15:0] sd_o // Write data
);
  logic [15:0] rd_q; // Data seen at cycle end
  logic [15:0] oe_q; // Drive enables at cycle end
  logic waited; // Ready seen low
  logic cs_low; // Word acknowledge seen
  logic hung; // A cycle never saw ready
  initial
  begin
    sa_o = 20'h00000;
    sbhe_n_o = 1'b1;
    st_n_o = 4'hF;
    sd_o = 16'h0000;
    hung = 1'b0;
  end
  // ==========================================================
  // One cycle; caller gives lanes by byte-high and SA0
  task automatic cyc(input logic [1:0] k, input logic [19:0] a,
    input logic hi_n, input logic [15:0] d);
    int n;
    @(posedge clk_i);
    sa_o <= a;
    sbhe_n_o <= hi_n;
    sd_o <= d;
    st_n_o <= ~(4'h1 << k);
    waited = 1'b0;
    cs_low = 1'b0;
    for (n = 0; n < 300; n++)
    begin
      // Ready, data and enables are taken at the rising edge
      @(posedge clk_i);
      waited |= ~rdy_i;
      cs_low |= ~cs_n_i;
      rd_q = sd_i;
      oe_q = oe_n_i;
      if (n > 9 && rdy_i)
        break;
    end
    if (n == 300)
      hung = 1'b1;
    // Release at the edge that saw ready; byte high is pulled up
    st_n_o <= 4'hF;
    sbhe_n_o <= 1'b1;
    sd_o <= ~d;
    repeat (5) @(posedge clk_i);
  endtask
endmodule // isa_master

// ==== test/tb_top.sv ====
// Purpose: self-checking bench for the host port
// Assumes: 40 MHz clock, reset held 4 cycles
// Notes: card side answers reads one cycle after the request
`timescale 1ns/10ps
module tb_top;
  import host_port_pkg::*;
  logic clk_i = 0, arst_n = 0, pwr = 1, strap = 0, rv = 0;
  logic [1:0] rdy = 2'b00; // Card drain ready
  logic [19:0] sa;
  logic [3:0] st;
  logic [15:0] sdm, sd, oe;
  logic hi_n, rdy_o, cs_io, cs_mem, rq;
  logic [1:0] cwv;
  card_req_t [1:0] cw;
  card_req_t crd;
  card_timing_t [1:0] tmg;
  int err_total = 0, checked = 0, ticks = 0;
  initial
    forever #12.5 clk_i = ~clk_i;
  // Card side answers each read request
  always @(posedge clk_i)
    rv <= rq;
  isa_host_port dut (.clk_i(clk_i), .arst_n_i(arst_n),
    .system_power_ok_i(pwr), .speaker_or_socket_select_pin_i(strap),
    .sa_i(sa), .sbhe_n_i(hi_n), .ior_n_i(st[0]), .iow_n_i(st[1]),
    .memr_n_i(st[2]), .memw_n_i(st[3]), .aen_i(1'b0), .sd_i(sdm),
    .sd_o(sd), .sd_oe_n_o(oe), .iochrdy_o(rdy_o), .iocs16_n_o(cs_io),
    .memcs16_n_o(cs_mem), .card_wr_o(cw), .card_wr_valid_o(cwv),
    .card_wr_ready_i(rdy), .card_rd_o(crd), .card_rd_req_o(rq),
    .card_rd_valid_i(rv), .card_rd_data_i(16'hA5C3),
    .card_timing_o(tmg));
  isa_master m (.clk_i(clk_i), .rdy_i(rdy_o), .sd_i(sd), .oe_n_i(oe),
    .cs_n_i(cs_io & cs_mem), .sa_o(sa), .sbhe_n_o(hi_n), .st_n_o(st),
    .sd_o(sdm));
  // ==========================================================
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (m.hung)
      err_total++;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
    m.cyc(2'd1, 20'h003E0, 1'b1, {8'h00, i});
    m.cyc(2'd1, 20'h003E1, 1'b1, {8'h00, d});
  endtask
  task automatic rd_reg(input logic [7:0] i);
    m.cyc(2'd1, 20'h003E0, 1'b1, {8'h00, i});
    m.cyc(2'd0, 20'h003E1, 1'b1, 16'h0000);
  endtask
  // ==========================================================
  task automatic t_regs;
    rd_reg(8'h3A);
    chk(m.rd_q[7:0], 8'h0C);
    chk(m.oe_q, 16'hFF00);
    chk({tmg[1], tmg[0]}, 48'h010700010600);
    wr_reg(8'h31, 8'h09);
    chk(tmg[0].cmd, 8'h09);
    @(posedge clk_i) pwr <= 1'b0;
    repeat (8) @(posedge clk_i);
    pwr <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk({tmg[1], tmg[0]}, 48'h010700010600);
    wr_reg(8'h2E, 8'h03);
    wr_reg(8'h2F, 8'h5A);
    rd_reg(8'h2F);
    chk(m.rd_q[7:0], 8'h5A);
    $display("t_regs done");
  endtask
  task automatic t_fifo;
    repeat (4)
    begin
      m.cyc(2'd3, 20'h00011, 1'b1, 16'h0041);
      chk(m.waited, 1'b0);
    end
    chk(cw[0].be, 2'b10);
    chk(cwv, 2'b01);
    fork
      m.cyc(2'd3, 20'h00020, 1'b1, 16'h0042);
      begin
        repeat (30) @(posedge clk_i);
        rdy <= 2'b11;
      end
    join
    chk(m.waited, 1'b1);
    $display("t_fifo done");
  endtask
  task automatic t_mask;
    wr_reg(8'h39, 8'h01); // buffers drained before
    m.cyc(2'd0, 20'h003F7, 1'b1, 16'h0000);
    chk(m.oe_q, 16'hFF80);
    chk({crd.addr, crd.be}, 22'h00FDE);
    chk(m.rd_q[6:0], 7'h25);
    wr_reg(8'h39, 8'h02);
    m.cyc(2'd0, 20'h00377, 1'b1, 16'h0000);
    chk(m.oe_q, 16'hFF7F);
    $display("t_mask done");
  endtask
  task automatic t_wide;
    m.cyc(2'd1, 20'h003E0, 1'b1, 16'h003A);
    m.cyc(2'd0, 20'h003E1, 1'b0, 16'h0000);
    m.cyc(2'd0, 20'h003E1, 1'b1, 16'h0000);
    chk(m.oe_q, 16'hFFFF);
    m.cyc(2'd0, 20'h003E0, 1'b0, 16'h0000);
    chk(m.rd_q, 16'h0D3A);
    chk({m.oe_q, m.cs_low}, 17'h00001);
    $display("t_wide done");
  endtask
  task automatic t_rst;
    @(posedge clk_i) strap <= 1'b1;
    rdy <= 2'b00;
    arst_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd_reg(8'h2F);
    chk(m.rd_q[7:0], 8'h5A);
    rd_reg(8'h3A);
    chk(m.rd_q[7:0], 8'h0E);
    m.cyc(2'd3, 20'h00010, 1'b1, 16'h0000);
    chk(cwv, 2'b10);
    $display("t_rst done");
  endtask
  // ==========================================================
  always @(posedge clk_i)
  begin
    ticks <= ticks + 1;
    if (ticks == 20000)
    begin
      err_total++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    t_regs;
    t_fifo;
    t_mask;
    t_wide;
    t_rst;
    print_verdict;
  end
endmodule // tb_top
